//--- hw/prag_cfg.svh
// Constants of the protected range access guard: register offset, field positions and reset values.
// Assumes inclusion by bare name from package and modules.
`ifndef PRAG_CFG_SVH
`define PRAG_CFG_SVH
`define PRAG_CTRL_OFFSET   8'h04
`define PRAG_UPPER_HI      31
`define PRAG_UPPER_LO      20
`define PRAG_OTHER_WR_BIT  18
`define PRAG_OTHER_RD_BIT  17
`define PRAG_LOWER_HI      15
`define PRAG_LOWER_LO      4
`define PRAG_CPU_WR_BIT    2
`define PRAG_CPU_RD_BIT    1
`define PRAG_LOCK_BIT      0
`define PRAG_BOUND_RESET   12'h000
`define PRAG_OPEN_RESET    1'b1
`define PRAG_LOCK_RESET    1'b0
`define PRAG_ADDR_BLK_HI   31
`define PRAG_ADDR_BLK_LO   20
`endif

//--- hw/prag_pkg.sv
// Types shared by the protected range access guard.
// Assumes prag_cfg.svh for field constants.
`include "prag_cfg.svh"
package prag_pkg;
    typedef struct packed {
        logic [11:0] window_upper_bound;
        logic        other_agent_write_open;
        logic        other_agent_read_open;
        logic [11:0] window_lower_bound;
        logic        cpu_write_open;
        logic        cpu_read_open;
        logic        window_config_lock;
    } prag_ctrl_s;

    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic        write;
        logic        from_cpu;
        logic        mgmt_mode;
    } prag_req_s;

    typedef struct packed {
        logic valid;
        logic allow;
        logic in_window;
    } prag_resp_s;
endpackage

//--- hw/prag_window_check.sv
// Combinational window compare and access decision for one request.
// Assumes control fields are stable register outputs on the same clock.
`timescale 1ns/1ns
`default_nettype none
`include "prag_cfg.svh"
module prag_window_check
    import prag_pkg::*;
(
    input  wire prag_ctrl_s ctrl_i,
    input  wire prag_req_s  req_i,
    output prag_resp_s      resp_o
);
    logic [11:0] blk;
    logic        in_win;
    logic        open_ok;

    always_comb
    begin
        blk    = req_i.addr[`PRAG_ADDR_BLK_HI:`PRAG_ADDR_BLK_LO];
        // Inclusive bounds, whole top block protected
        in_win = (blk >= ctrl_i.window_lower_bound) && (blk <= ctrl_i.window_upper_bound);
        if (req_i.from_cpu)
        begin
            open_ok = req_i.mgmt_mode
                    || (req_i.write ? ctrl_i.cpu_write_open : ctrl_i.cpu_read_open);
        end
        else
        begin
            open_ok = req_i.write ? ctrl_i.other_agent_write_open : ctrl_i.other_agent_read_open;
        end
        resp_o.valid     = req_i.valid;
        resp_o.in_window = req_i.valid && in_win;
        resp_o.allow     = req_i.valid && (!in_win || open_ok);
    end
endmodule
`default_nettype wire

//--- hw/prag_top.sv
// Protected range access guard: control register on the message port and registered access decision.
// Assumes request and port signals come from logic on core_clk_i; one access decision per cycle.
//
// Operation
// - Upper bound field bits 31:20, resets zero
// - Lower bound field bits 15:4, resets zero
// - Lower bound low twenty address bits are zero, upper bound all ones
// - Write-open lets non-management cpu writes
// - Read-open lets non-management cpu reads
// - Bit 18 permits other-agent writes
// - Bit 17 permits other-agent reads
// - Lock bit write-once, freezes register
`timescale 1ns/1ns
`default_nettype none
`include "prag_cfg.svh"
module prag_top
    import prag_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [3:0]  reg_be_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic [31:0]      reg_rdata_o,
    output logic             reg_rvalid_o,
    input  wire prag_req_s   req_i,
    output prag_resp_s       resp_o
);
    typedef struct packed {
        prag_ctrl_s  ctrl;
        logic [31:0] rdata;
        logic        rvalid;
        prag_resp_s  resp;
    } prag_state_s;

    prag_state_s st;
    prag_state_s next_st;
    prag_resp_s  chk;
    logic [31:0] cur_word;
    logic [31:0] new_word;
    logic        hit;
    logic        wr_hit;
    logic        rd_hit;
    logic        wr_take;
    logic [31:0] lane_mask;

    prag_window_check u_check (
        .ctrl_i (st.ctrl),
        .req_i  (req_i),
        .resp_o (chk)
    );

    // Register image of the control fields; reserved positions read as zero
    function automatic logic [31:0] ctrl_to_word(input prag_ctrl_s c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`PRAG_UPPER_HI:`PRAG_UPPER_LO] = c.window_upper_bound;
        w[`PRAG_OTHER_WR_BIT]            = c.other_agent_write_open;
        w[`PRAG_OTHER_RD_BIT]            = c.other_agent_read_open;
        w[`PRAG_LOWER_HI:`PRAG_LOWER_LO] = c.window_lower_bound;
        w[`PRAG_CPU_WR_BIT]              = c.cpu_write_open;
        w[`PRAG_CPU_RD_BIT]              = c.cpu_read_open;
        w[`PRAG_LOCK_BIT]                = c.window_config_lock;
        return w;
    endfunction

    // Field picks from a merged word; reserved positions are dropped here
    function automatic prag_ctrl_s word_to_ctrl(input logic [31:0] w);
        prag_ctrl_s c;
        c.window_upper_bound     = w[`PRAG_UPPER_HI:`PRAG_UPPER_LO];
        c.other_agent_write_open = w[`PRAG_OTHER_WR_BIT];
        c.other_agent_read_open  = w[`PRAG_OTHER_RD_BIT];
        c.window_lower_bound     = w[`PRAG_LOWER_HI:`PRAG_LOWER_LO];
        c.cpu_write_open         = w[`PRAG_CPU_WR_BIT];
        c.cpu_read_open          = w[`PRAG_CPU_RD_BIT];
        c.window_config_lock     = w[`PRAG_LOCK_BIT];
        return c;
    endfunction

    // Byte enables select lanes; a partial write keeps the other lanes
    for (genvar lane = 0; lane < 4; lane++)
    begin : g_lane
        assign lane_mask[lane*8 +: 8] = {8{reg_be_i[lane]}};
    end

    always_comb
    begin
        cur_word = ctrl_to_word(st.ctrl);
        new_word = (reg_wdata_i & lane_mask) | (cur_word & ~lane_mask);
        hit      = reg_addr_i == `PRAG_CTRL_OFFSET;
        wr_hit   = reg_wr_i && hit;
        rd_hit   = reg_rd_i && hit;
        // Locked register drops every write whole until reset
        wr_take  = wr_hit && !st.ctrl.window_config_lock;

        next_st        = st;
        next_st.rvalid = reg_rd_i;
        // A read beside a write returns the value before the write
        next_st.rdata  = rd_hit ? cur_word : 32'h0000_0000;
        next_st.resp   = chk;
        if (wr_take)
        begin
            next_st.ctrl = word_to_ctrl(new_word);
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!nrst_i)
        begin
            st <= '0;
            st.ctrl.window_upper_bound     <= `PRAG_BOUND_RESET;
            st.ctrl.window_lower_bound     <= `PRAG_BOUND_RESET;
            st.ctrl.other_agent_write_open <= `PRAG_OPEN_RESET;
            st.ctrl.other_agent_read_open  <= `PRAG_OPEN_RESET;
            st.ctrl.cpu_write_open         <= `PRAG_OPEN_RESET;
            st.ctrl.cpu_read_open          <= `PRAG_OPEN_RESET;
            st.ctrl.window_config_lock     <= `PRAG_LOCK_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign reg_rdata_o  = st.rdata;
    assign reg_rvalid_o = st.rvalid;
    assign resp_o       = st.resp;
endmodule
`default_nettype wire

//--- verif/prag_top_monitor.sv
// Assertions on the guard's register and access ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module prag_top_monitor
    import prag_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        reg_rd_i,
    input wire logic        reg_rvalid_o,
    input wire logic [7:0]  reg_addr_i,
    input wire logic [31:0] reg_rdata_o,
    input wire prag_req_s   req_i,
    input wire prag_resp_s  resp_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic rd4 = reg_rd_i && reg_addr_i == 8'h04;
    wire logic cm = req_i.valid && req_i.from_cpu && req_i.mgmt_mode;
    property p_rsv; reg_rvalid_o |-> (reg_rdata_o & 32'h00090008) == 0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved set");
    property p_unm; reg_rd_i && reg_addr_i != 8'h04 |=> reg_rdata_o == 0; endproperty
    a_unm: assert property (p_unm) else $error("unmapped data");
    property p_lock; rd4 ##1 rd4 && reg_rdata_o[0] |=> $stable(reg_rdata_o); endproperty
    a_lock: assert property (p_lock) else $error("locked changed");
    property p_rsp; req_i.valid |=> resp_o.valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no answer");
    property p_idl; !req_i.valid |=> !resp_o.valid; endproperty
    a_idl: assert property (p_idl) else $error("spurious answer");
    property p_out; resp_o.valid && !resp_o.in_window |-> resp_o.allow; endproperty
    a_out: assert property (p_out) else $error("outside blocked");
    property p_mw; cm && req_i.write |=> resp_o.allow; endproperty
    a_mw: assert property (p_mw) else $error("mgmt write blocked");
    property p_mr; cm && !req_i.write |=> resp_o.allow; endproperty
    a_mr: assert property (p_mr) else $error("mgmt read blocked");
endmodule
bind prag_top prag_top_monitor u_mon (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_rd_i(reg_rd_i),
    .reg_rvalid_o(reg_rvalid_o), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .req_i(req_i),
    .resp_o(resp_o));
`default_nettype wire

//--- verif/prag_req_model.sv
// Requester model: host processor or other agent presenting one access.
// Assumes fields change just after a clock edge.
`timescale 1ns/1ns
`default_nettype none
module prag_req_model
    import prag_pkg::*;
(
    input  wire logic        valid_i,
    input  wire logic [31:0] addr_i,
    input  wire logic [2:0]  kind_i,
    output var prag_req_s    req_o
);
    // Idle address inverted so a stale one never looks valid
    assign req_o = '{valid_i, valid_i ? addr_i : ~addr_i, kind_i[2], kind_i[1], kind_i[0]};
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench: register, lock and window decisions against a bench model.
// Assumes prag_top and prag_req_model; 40 ns clock.
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import prag_pkg::*;
;
    logic        core_clk_i, nrst_i, reg_wr_i, reg_rd_i, valid, reg_rvalid_o;
    logic [7:0]  reg_addr_i;
    logic [3:0]  reg_be_i;
    logic [31:0] reg_wdata_i, reg_rdata_o, addr, m, x;
    logic [2:0]  kind;
    logic [15:0] lf;
    prag_req_s   req_i;
    prag_resp_s  resp_o;
    int          num_errors, total_checks;
    prag_req_model u_prag_req_model (.valid_i(valid), .addr_i(addr), .kind_i(kind), .req_o(req_i));
    prag_top u_prag_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .req_i(req_i), .resp_o(resp_o));
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    function automatic logic [31:0] rnd();
        repeat (32) lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return {lf, lf[7:0], lf[15:8]};
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // One cycle on both ports; results land one edge later
    task automatic op(input logic w, r, input logic [7:0] a, input logic [3:0] be,
                      input logic [31:0] d, input logic v);
        logic [31:0] bm, old;
        logic        in, al;
        old = m;
        x = rnd();
        addr = {x[1] ? m[31:20] : x[0] ? m[15:4] : x[31:20], x[19:0]};
        {kind, valid, reg_wr_i, reg_rd_i, reg_addr_i, reg_be_i, reg_wdata_i} = {x[4:2], v, w, r, a, be, d};
        in = addr[31:20] >= m[15:4] && addr[31:20] <= m[31:20];
        al = !in || (kind[1] ? kind[0] || (kind[2] ? m[2] : m[1]) : (kind[2] ? m[18] : m[17]));
        bm = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & 32'hfff6fff7;
        if (w && a == 8'h04 && !m[0]) m = (m & ~bm) | (d & bm);
        @(posedge core_clk_i);
        #1;
        chk(reg_rvalid_o, r);
        if (r) chk(reg_rdata_o, a == 8'h04 ? old : 32'h0);
        chk(resp_o, v ? {1'b1, al, in} : 3'b000);
    endtask
    initial
    begin
        lf = 16'hde1f;
        m = 32'h00060006;
        {nrst_i, reg_wr_i, reg_rd_i, valid, reg_addr_i, reg_be_i, reg_wdata_i, addr, kind} = '0;
        repeat (3) @(posedge core_clk_i);
        #1 nrst_i = 1'b1;
        op(1'b0, 1'b1, 8'h04, 4'h0, 32'h0, 1'b1);
        op(1'b1, 1'b1, 8'h04, 4'hf, 32'hffffffff, 1'b1);
        op(1'b0, 1'b1, 8'h04, 4'h0, 32'h0, 1'b1);
        repeat (80) op(x[5], x[6], x[7] ? 8'h04 : x[15:8], x[19:16], rnd() & 32'hfffffffe, x[8]);
        $display("test random access done");
        op(1'b1, 1'b0, 8'h04, 4'hf, 32'h3ff03ff6, 1'b1);
        op(1'b1, 1'b1, 8'h04, 4'hf, 32'h3ff03ff1, 1'b1);
        op(1'b0, 1'b1, 8'h04, 4'h0, 32'h0, 1'b1);
        op(1'b1, 1'b1, 8'h04, 4'hf, 32'h0, 1'b1);
        op(1'b0, 1'b1, 8'h04, 4'h0, 32'h0, 1'b1);
        repeat (30) op(1'b0, 1'b0, 8'h04, 4'h0, 32'h0, 1'b1);
        $display("test lock done");
        // Reset in mid-run must clear the lock and restore the open bits
        nrst_i = 1'b0;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk(reg_rvalid_o, 1'b0);
        chk(reg_rdata_o, 32'h0);
        chk(resp_o, 32'h0);
        nrst_i = 1'b1;
        m = 32'h00060006;
        op(1'b1, 1'b1, 8'h04, 4'hf, 32'h3ff03ff6, 1'b1);
        op(1'b0, 1'b1, 8'h04, 4'h0, 32'h0, 1'b1);
        $display("test reset done");
        print_verdict();
    end
    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        num_errors++;
        print_verdict();
    end
endmodule
`default_nettype wire
